// *** include/crs_pkg.sv ***
// Package of constants and types for the command response status block
// ****************************************************************
// ****************************************************************
package crs_pkg;

    // Register offset and field positions
    localparam logic [7:0] CRS_REG_OFFSET = 8'h11;
    localparam int CRS_BIT_RUNNING = 7;
    localparam int CRS_BIT_SUSPEND = 6;
    localparam int CRS_BIT_SLEEP = 5;
    localparam int CRS_BIT_FAULT = 4;

    // Reset values
    localparam logic [3:0] CRS_TALLY_PRESET = 4'hf;
    localparam logic [3:0] CRS_TALLY_ZERO = 4'h0;
    localparam logic CRS_FAULT_RESET = 1'b0;

    // Error codes; only the low nibble fits the field
    localparam logic [7:0] CRS_ERR_BAD_CMD = 8'h10;
    localparam logic [7:0] CRS_ERR_BAD_PARAM = 8'h11;
    localparam logic [7:0] CRS_ERR_SATURATE = 8'h12;
    localparam logic [7:0] CRS_ERR_OUT_OVF = 8'h13;
    localparam int CRS_OUT_BUF_BYTES = 26;

    // Initialization time after any reset
    localparam int CRS_INIT_TIME_NS = 1000;
    localparam int CRS_CLK_PERIOD_NS = 10;
    localparam int CRS_INIT_CYCLES = (CRS_INIT_TIME_NS + CRS_CLK_PERIOD_NS - 1) / CRS_CLK_PERIOD_NS;

    // Controller states shown in the top three bits
    typedef enum logic [1:0] {
        CRS_ST_RUNNING,
        CRS_ST_SUSPEND,
        CRS_ST_SLEEP
    } crs_state_t;

    // Command completion events from the controller
    typedef struct packed {
        logic good;
        logic bad_cmd;
        logic bad_param;
        logic saturate;
        logic tally_clear;
        logic soft_restart;
    } crs_event_t;

    // Host register access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crs_host_t;

endpackage : crs_pkg

// *** logic/crs_response.sv ***
// Command response and status register with its tally and fault logic
`timescale 1ns/1ns
module crs_response (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire crs_pkg::crs_event_t evt_in,
    input wire logic suspend_in,
    input wire logic busy_in,
    input wire logic burst_en_in,
    input wire logic [5:0] burst_bytes_in,
    input wire crs_pkg::crs_host_t host_in,
    output logic [7:0] rdata_out,
    output logic [7:0] status_out,
    output logic init_done_out
);
    import crs_pkg::*;

    // ****************************************************************
    // Initialization timer
    // ****************************************************************
    localparam logic [7:0] INIT_LAST = 8'(CRS_INIT_CYCLES - 1);
    logic [7:0] init_cnt_r;
    logic init_done_r;
    logic burst_ovf;
    logic [3:0] tally_r;
    logic fault_r;
    logic [3:0] code_r;
    crs_state_t state_r;
    logic [7:0] status_nxt;

    // Overflow when burst output needs more than the buffer holds
    assign burst_ovf = burst_en_in && (burst_bytes_in > 6'(CRS_OUT_BUF_BYTES));

    // Soft restart reruns initialization like power-up
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            init_cnt_r <= 8'h00;
            init_done_r <= 1'b0;
        end else if (evt_in.soft_restart) begin
            init_cnt_r <= 8'h00;
            init_done_r <= 1'b0;
        end else if (!init_done_r) begin
            if (init_cnt_r == INIT_LAST) begin
                init_done_r <= 1'b1;
            end else begin
                init_cnt_r <= init_cnt_r + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Controller state indicator
    // ****************************************************************
    // Running until init ends, then sleeping unless busy or suspended
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= CRS_ST_RUNNING;
        end else if (evt_in.soft_restart || !init_done_r) begin
            state_r <= CRS_ST_RUNNING;
        end else if (busy_in) begin
            state_r <= CRS_ST_RUNNING;
        end else if (suspend_in) begin
            state_r <= CRS_ST_SUSPEND;
        end else begin
            state_r <= CRS_ST_SLEEP;
        end
    end

    // ****************************************************************
    // Fault flag and error code
    // ****************************************************************
    // Any error wins over a clear in the same cycle; burst overflow is ignored until init is done
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fault_r <= CRS_FAULT_RESET;
            code_r <= CRS_TALLY_ZERO;
        end else if (evt_in.bad_cmd) begin
            fault_r <= 1'b1;
            code_r <= CRS_ERR_BAD_CMD[3:0];
        end else if (evt_in.bad_param) begin
            fault_r <= 1'b1;
            code_r <= CRS_ERR_BAD_PARAM[3:0];
        end else if (evt_in.saturate) begin
            fault_r <= 1'b1;
            code_r <= CRS_ERR_SATURATE[3:0];
        end else if (burst_ovf && init_done_r) begin
            fault_r <= 1'b1;
            code_r <= CRS_ERR_OUT_OVF[3:0];
        end else if (evt_in.soft_restart || evt_in.tally_clear) begin
            fault_r <= CRS_FAULT_RESET;
            code_r <= CRS_TALLY_ZERO;
        end
    end

    // ****************************************************************
    // Command tally
    // ****************************************************************
    // Counts only while no fault; wraps in four bits
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tally_r <= CRS_TALLY_PRESET;
        end else if (evt_in.soft_restart) begin
            tally_r <= CRS_TALLY_PRESET;
        end else if (evt_in.tally_clear) begin
            tally_r <= CRS_TALLY_ZERO;
        end else if (evt_in.good && !fault_r) begin
            tally_r <= tally_r + 4'h1;
        end
    end

    // ****************************************************************
    // Register image and host port
    // ****************************************************************
    // Low nibble shows the error code while faulted
    always_comb begin
        status_nxt = 8'h00;
        status_nxt[CRS_BIT_RUNNING] = (state_r == CRS_ST_RUNNING);
        status_nxt[CRS_BIT_SUSPEND] = (state_r == CRS_ST_SUSPEND);
        status_nxt[CRS_BIT_SLEEP] = (state_r == CRS_ST_SLEEP);
        status_nxt[CRS_BIT_FAULT] = fault_r;
        status_nxt[3:0] = fault_r ? code_r : tally_r;
    end

    // Image registered so outputs come from flops
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            status_out <= {3'b100, CRS_FAULT_RESET, CRS_TALLY_PRESET}; // Running, no fault, preset
            init_done_out <= 1'b0;
        end else begin
            status_out <= status_nxt;
            init_done_out <= init_done_r;
        end
    end

    // Reads are pure; writes are dropped as every bit is read-only
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= 8'h00;
        end else if (host_in.rd && host_in.addr == CRS_REG_OFFSET) begin
            rdata_out <= status_nxt;
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule : crs_response

// *** testbench/crs_host_model.sv ***
// Host model issuing register reads and writes
`timescale 1ns/1ns
module crs_host_model (
    input wire logic clk_in,
    input wire logic rd_req_in,
    input wire logic wr_req_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_in,
    output crs_pkg::crs_host_t host_out,
    output logic [7:0] rd_val_out
);
    import crs_pkg::*;
    logic rd_d_r = 1'b0;
    // Requests follow the bench strobes, always aimed at the register
    assign host_out = '{rd_req_in, wr_req_in, CRS_REG_OFFSET, wdata_in};
    // Read data stands one cycle only, so it is caught at the next edge
    always @(posedge clk_in) begin
        rd_d_r <= host_out.rd;
        if (rd_d_r) rd_val_out <= rdata_in;
    end
endmodule : crs_host_model

// *** testbench/crs_response_assertions.sv ***
// Concurrent checks on the response register ports
`timescale 1ns/1ns
module crs_response_assertions (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire crs_pkg::crs_event_t evt_in,
    input wire logic suspend_in,
    input wire logic busy_in,
    input wire logic burst_en_in,
    input wire logic [5:0] burst_bytes_in,
    input wire crs_pkg::crs_host_t host_in,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] status_out,
    input wire logic init_done_out
);
    import crs_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Events land on status one edge after they are taken, so checks look ##2 on
    rd_idle_a: assert property (!(host_in.rd && host_in.addr == CRS_REG_OFFSET) |=> !rdata_out)
        else $error("read data without a read");
    init_hold_a: assert property (!init_done_out |-> status_out[7])
        else $error("running not shown during init");
    bad_cmd_a: assert property (evt_in.bad_cmd && !evt_in.soft_restart |-> ##2 status_out[4:0] == 5'h10)
        else $error("bad command code wrong");
    bad_param_a: assert property (evt_in.bad_param && evt_in[4] == 1'b0
        && !evt_in.soft_restart |-> ##2 status_out[4:0] == 5'h11)
        else $error("bad parameter code wrong");
    fault_code_a: assert property (status_out[4] |-> status_out[3:2] == 2'b00)
        else $error("fault code out of range");
    clear_tally_a: assert property (evt_in.tally_clear && evt_in[4:2] == 3'b000
        && !evt_in.soft_restart && !burst_en_in |-> ##2 status_out[4:0] == 5'h00)
        else $error("clear failed");
    good_step_a: assert property (evt_in == 6'h20 && $past(evt_in) == 6'h00
        && !status_out[4] && !burst_en_in && init_done_out
        |-> ##2 status_out[3:0] == $past(status_out[3:0], 2) + 4'h1)
        else $error("tally did not step");
    restart_a: assert property (evt_in.soft_restart |-> ##2 status_out == 8'h8f && !init_done_out)
        else $error("restart image wrong");
endmodule : crs_response_assertions
bind crs_response crs_response_assertions crs_response_assertions_i (.*);

// *** testbench/tb_top.sv ***
// Self-checking bench of the response register
`timescale 1ns/1ns
module tb_top;
    import crs_pkg::*;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, suspend_in = 1'b0, busy_in = 1'b0, burst_en_in = 1'b0;
    logic rd_q = 1'b0, wr_q = 1'b0, flt = 1'b0, init_done_out;
    logic [5:0] burst_bytes_in = 6'd0;
    logic [7:0] rdata_out, status_out, rd_val;
    logic [31:0] lf = 32'h16003b12;
    logic [3:0] tally = 4'hf, code = 4'h0;
    logic [2:0] st = 3'b001;
    crs_event_t evt_in = '0;
    crs_host_t host_in;
    int failures, samples_checked, cyc, i;
    crs_response crs_response_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .evt_in(evt_in),
        .suspend_in(suspend_in), .busy_in(busy_in), .burst_en_in(burst_en_in),
        .burst_bytes_in(burst_bytes_in), .host_in(host_in), .rdata_out(rdata_out),
        .status_out(status_out), .init_done_out(init_done_out));
    crs_host_model crs_host_model_i (.clk_in(clk_in), .rd_req_in(rd_q), .wr_req_in(wr_q),
        .wdata_in(lf[7:0]), .rdata_in(rdata_out), .host_out(host_in), .rd_val_out(rd_val));
    always #5 clk_in = ~clk_in;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 1000) begin failures++; end_of_test(); end
    end
    function automatic logic [31:0] lfsr_f(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_f
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin failures++; $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g); end
    endtask : chk
    // Reference model: errors beat clear, good pulses frozen by a fault
    task automatic mdl(input crs_event_t e);
        if (e.soft_restart) begin tally = 4'hf; flt = 1'b0; st = 3'b100; end
        else if (e[4:2] != 3'b000) begin flt = 1'b1; code = e.bad_cmd ? 4'h0 : e.bad_param ? 4'h1 : 4'h2; end
        else if (e.tally_clear) begin tally = 4'h0; flt = 1'b0; end
        else if (e.good && !flt) tally = tally + 4'h1;
    endtask : mdl
    // Holds one event for n back-to-back cycles, then compares the image
    task automatic ev(input crs_event_t e, input int n);
        evt_in = e;
        repeat (n) begin @(negedge clk_in); mdl(e); end
        evt_in = '0;
        @(negedge clk_in);
        chk({st, flt, flt ? code : tally}, status_out);
    endtask : ev
    task automatic end_of_test();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (6) @(negedge clk_in);
        sys_rst_in = 1'b0;
        chk(8'h8f, status_out);
        repeat (CRS_INIT_CYCLES + 2) @(negedge clk_in);
        chk(8'h2f, status_out);
        for (i = 0; i < 3; i++) begin
            busy_in = (i == 0);
            suspend_in = (i == 1);
            repeat (3) @(negedge clk_in);
            chk({3'b100 >> i, 5'h0f}, status_out);
        end
        lf = lfsr_f(lf);
        ev(crs_event_t'(6'h20), int'(lf[3:0]) + 2);
        // Write is ignored, read returns the image with no side effect
        wr_q = 1'b1;
        @(negedge clk_in);
        wr_q = 1'b0;
        rd_q = 1'b1;
        @(negedge clk_in);
        rd_q = 1'b0;
        ev('0, 2);
        chk({st, flt, tally}, rd_val);
        ev(crs_event_t'(6'h02), 1);
        for (i = 0; i < 3; i++) begin
            ev(crs_event_t'(6'h10 >> i), 1);
            ev(crs_event_t'(6'h20), 2);
            ev(crs_event_t'(6'h02), 1);
        end
        burst_en_in = 1'b1;
        burst_bytes_in = 6'd26;
        ev('0, 3);
        burst_bytes_in = 6'd27;
        flt = 1'b1;
        code = 4'h3;
        ev('0, 3);
        burst_en_in = 1'b0;
        ev(crs_event_t'(6'h01), 1);
        chk(8'h00, {7'h00, init_done_out});
        repeat (CRS_INIT_CYCLES + 2) @(negedge clk_in);
        chk(8'h2f, status_out);
        end_of_test();
    end
endmodule : tb_top
